// >>> reset_cause_cfg.svh
/*
 * Constants for the reset cause recorder: register offsets, field positions,
 * reset values, restart addresses and phase counts.
 * Assumes it is included by bare name before the package and the module.
 */
`ifndef RESET_CAUSE_CFG_SVH
`define RESET_CAUSE_CFG_SVH

// register byte offsets
`define OFS_CAUSE      8'h00
`define OFS_RESTART    8'h04
`define OFS_IRQ_STATUS 8'h08
`define OFS_IRQ_ENABLE 8'h0C
`define OFS_IRQ_CLEAR  8'h10
`define OFS_CTRL       8'h14

// cause flag positions
`define B_TRAP   0
`define B_ILLOP  1
`define B_EXT    2
`define B_SWR    3
`define B_WDT    4
`define B_IDLE   5
`define B_SLEEP  6
`define B_POR    7
`define B_BOR    8
`define CAUSE_W  9

// power-on value of the cause register: power-on and brown-out set
`define CAUSE_POR_VAL 9'h180

// restart addresses
`define PC_W          24
`define PC_RESET      24'h000000
`define PC_CLKFAIL    24'h000004
`define PC_STEP       24'h000002

// instruction cycle phases
`define QUARTERS      2'h3
`define Q_HIGH_FIRST  2'h2

// ctrl bit fields
`define C_SLEEPING 0
`define C_IDLING   1

`define AXI_OKAY   2'h0
`define AXI_SLVERR 2'h2

`endif

// >>> reset_cause_pkg.sv
/*
 * Types for the reset cause recorder.
 * Assumes reset_cause_cfg.svh is on the include path.
 */
`include "reset_cause_cfg.svh"
package reset_cause_pkg;
	// one pulse per event source
	typedef struct packed {
		logic por;
		logic bor;
		logic master_clear_input;
		logic software_reset_flag;
		logic wdt_timeout;
		logic wdt_wake;
		logic irq_wake;
		logic irq_vec_valid;
		logic clk_fail;
		logic trap;
		logic illop;
	} event_t;

	// restart request to the core
	typedef struct packed {
		logic            valid;
		logic [`PC_W-1:0] pc;
	} restart_t;

	typedef enum logic [1:0] {
		MODE_RUN,
		MODE_SLEEP,
		MODE_IDLE
	} cpu_mode_t;
endpackage

// >>> reset_cause_flag_recorder.sv
/*
 * Reset cause flag recorder with AXI4-Lite register access, restart vector
 * selection, instruction cycle divider and event interrupt.
 * Assumes event inputs are one-cycle pulses synchronous to clk, and that
 * the core samples the restart request on the cycle after an event.
 */
`timescale 1ns/1ps
`default_nettype none
`include "reset_cause_cfg.svh"

// Contract
// - power-on sets power-on and brown-out flags, clears all others, restarts at zero
// - brown-out sets brown-out, clears power-on; software reset sets its flag, clears ext/wdt/idle/sleep
// - master clear sets external, clears watchdog and idle; sleep sets sleep flag
// - master clear while idle sets external and idle, clears watchdog, sleep, keeps software
// - watchdog reset sets watchdog, clears ext/sw/idle/sleep; trap and illegal set own flag
// - watchdog wake sets watchdog and sleep, next instruction; interrupt wake sets sleep only
// - interrupt wake with enabled interrupt restarts at that interrupt's vector
// - clock failure trap vectors to four and leaves all flags unchanged
// - instruction cycle is exactly four oscillator periods
// - cycle clock output low in first two quarters, high in last two
// - all cause flags readable and writable by software
module reset_cause_flag_recorder (
	input  wire logic                    clk,           // oscillator clock
	input  wire logic                    rst_n,         // sync reset, active low
	input  wire reset_cause_pkg::event_t ev,            // event pulses
	input  wire logic [`PC_W-1:0]        cur_pc,        // pc of sleep instruction
	input  wire logic [`PC_W-1:0]        irq_vector,    // vector of waking interrupt
	input  wire logic [31:0]             s_awaddr,      // axi write address
	input  wire logic                    s_awvalid,     // axi
	output logic                         s_awready,     // axi
	input  wire logic [31:0]             s_wdata,       // axi
	input  wire logic [3:0]              s_wstrb,       // axi
	input  wire logic                    s_wvalid,      // axi
	output logic                         s_wready,      // axi
	output logic [1:0]                   s_bresp,       // axi
	output logic                         s_bvalid,      // axi
	input  wire logic                    s_bready,      // axi
	input  wire logic [31:0]             s_araddr,      // axi
	input  wire logic                    s_arvalid,     // axi
	output logic                         s_arready,     // axi
	output logic [31:0]                  s_rdata,       // axi
	output logic [1:0]                   s_rresp,       // axi
	output logic                         s_rvalid,      // axi
	input  wire logic                    s_rready,      // axi
	output reset_cause_pkg::restart_t    restart,       // restart request
	output logic                         cycle_clock_output, // instruction clock out
	output logic [1:0]                   quarter,       // current quarter phase
	output logic                         irq            // level interrupt
);
	import reset_cause_pkg::*;

	logic [`CAUSE_W-1:0] reset_cause_register;
	logic [`CAUSE_W-1:0] next_cause;
	logic [`CAUSE_W-1:0] irq_status;
	logic [`CAUSE_W-1:0] irq_enable;
	logic [`CAUSE_W-1:0] cause_set;
	logic [1:0]          ctrl;
	logic                any_event;
	logic                aw_hold;
	logic                w_hold;
	logic [31:0]         aw_addr;
	logic [31:0]         w_data;
	logic [3:0]          w_strb;
	logic                wr_fire;
	logic                sw_cause_wr;
	logic                sw_ctrl_wr;
	logic                sw_en_wr;
	logic                sw_clr_wr;
	logic                wr_hit;

	////////////////////////////////////////////////////////////////////////
	// axi4-lite write channel
	assign wr_fire     = aw_hold && w_hold && !s_bvalid;
	assign wr_hit      = (aw_addr[7:0] == `OFS_CAUSE) || (aw_addr[7:0] == `OFS_IRQ_ENABLE) ||
	                     (aw_addr[7:0] == `OFS_IRQ_CLEAR) || (aw_addr[7:0] == `OFS_CTRL);
	assign sw_cause_wr = wr_fire && (aw_addr[7:0] == `OFS_CAUSE);
	assign sw_ctrl_wr  = wr_fire && (aw_addr[7:0] == `OFS_CTRL);
	assign sw_en_wr    = wr_fire && (aw_addr[7:0] == `OFS_IRQ_ENABLE);
	assign sw_clr_wr   = wr_fire && (aw_addr[7:0] == `OFS_IRQ_CLEAR);

	// address and data taken in either order, held until the response
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			aw_hold   <= 1'b0;
			w_hold    <= 1'b0;
			aw_addr   <= 32'h00000000;
			w_data    <= 32'h00000000;
			w_strb    <= 4'h0;
			s_awready <= 1'b0;
			s_wready  <= 1'b0;
			s_bvalid  <= 1'b0;
			s_bresp   <= `AXI_OKAY;
		end else begin
			s_awready <= !aw_hold && !s_awready && s_awvalid;
			s_wready  <= !w_hold && !s_wready && s_wvalid;
			if (s_awvalid && s_awready) begin
				aw_hold <= 1'b1;
				aw_addr <= s_awaddr;
			end
			if (s_wvalid && s_wready) begin
				w_hold <= 1'b1;
				w_data <= s_wdata;
				w_strb <= s_wstrb;
			end
			if (wr_fire) begin
				s_bvalid <= 1'b1;
				s_bresp  <= wr_hit ? `AXI_OKAY : `AXI_SLVERR;
			end else if (s_bvalid && s_bready) begin
				s_bvalid <= 1'b0;
				aw_hold  <= 1'b0;
				w_hold   <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// axi4-lite read channel, one read at a time
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			s_arready <= 1'b0;
			s_rvalid  <= 1'b0;
			s_rdata   <= 32'h00000000;
			s_rresp   <= `AXI_OKAY;
		end else begin
			s_arready <= !s_rvalid && !s_arready && s_arvalid;
			if (s_arvalid && s_arready) begin
				s_rvalid <= 1'b1;
				s_rresp  <= `AXI_OKAY;
				s_rdata  <= 32'h00000000;
				case (s_araddr[7:0])
					`OFS_CAUSE:      s_rdata[`CAUSE_W-1:0] <= reset_cause_register;
					`OFS_RESTART:    s_rdata[`PC_W-1:0]    <= restart.pc;
					`OFS_IRQ_STATUS: s_rdata[`CAUSE_W-1:0] <= irq_status;
					`OFS_IRQ_ENABLE: s_rdata[`CAUSE_W-1:0] <= irq_enable;
					`OFS_IRQ_CLEAR:  s_rdata               <= 32'h00000000;
					`OFS_CTRL:       s_rdata[1:0]          <= ctrl;
					default:         s_rresp               <= `AXI_SLVERR;
				endcase
			end else if (s_rvalid && s_rready) begin
				s_rvalid <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// cpu mode: software tells the recorder when the core sleeps or idles
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			ctrl <= 2'h0;
		end else if (sw_ctrl_wr && w_strb[0]) begin
			ctrl <= w_data[1:0];
		end else if (ev.master_clear_input || ev.wdt_wake || ev.irq_wake || ev.por || ev.bor) begin
			ctrl <= 2'h0; // master clear, wakes, power-on and brown-out leave sleep and idle
		end
	end

	////////////////////////////////////////////////////////////////////////
	// flag update per event; precedence follows severity, power-on first
	always_comb begin
		next_cause = reset_cause_register;
		if (ev.por) begin
			next_cause = `CAUSE_POR_VAL;
		end else if (ev.bor) begin
			next_cause[`B_BOR] = 1'b1;
			next_cause[`B_POR] = 1'b0;
		end else if (ev.master_clear_input) begin
			next_cause[`B_EXT]  = 1'b1;
			next_cause[`B_WDT]  = 1'b0;
			next_cause[`B_IDLE] = ctrl[`C_IDLING];
			next_cause[`B_SLEEP] = ctrl[`C_SLEEPING] && !ctrl[`C_IDLING];
			if (!ctrl[`C_SLEEPING] && !ctrl[`C_IDLING]) begin
				next_cause[`B_SWR] = 1'b0;
			end
		end else if (ev.software_reset_flag) begin
			next_cause[`B_SWR]   = 1'b1;
			next_cause[`B_EXT]   = 1'b0;
			next_cause[`B_WDT]   = 1'b0;
			next_cause[`B_IDLE]  = 1'b0;
			next_cause[`B_SLEEP] = 1'b0;
		end else if (ev.wdt_timeout) begin
			next_cause[`B_WDT]   = 1'b1;
			next_cause[`B_EXT]   = 1'b0;
			next_cause[`B_SWR]   = 1'b0;
			next_cause[`B_IDLE]  = 1'b0;
			next_cause[`B_SLEEP] = 1'b0;
		end else if (ev.trap) begin
			next_cause[`B_TRAP] = 1'b1;
		end else if (ev.illop) begin
			next_cause[`B_ILLOP] = 1'b1;
		end else if (ev.wdt_wake) begin
			next_cause[`B_WDT]   = 1'b1;
			next_cause[`B_SLEEP] = 1'b1;
		end else if (ev.irq_wake) begin
			next_cause[`B_SLEEP] = 1'b1;
		end else if (sw_cause_wr) begin
			next_cause[7:0] = w_strb[0] ? w_data[7:0] : reset_cause_register[7:0];
			next_cause[`B_BOR] = w_strb[1] ? w_data[`B_BOR] : reset_cause_register[`B_BOR];
		end
		// clock failure: nothing changes here, all flags kept
	end

	assign any_event = ev.por || ev.bor || ev.master_clear_input || ev.software_reset_flag || ev.wdt_timeout || ev.trap ||
	                   ev.illop || ev.wdt_wake || ev.irq_wake || ev.clk_fail;

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			reset_cause_register <= `CAUSE_POR_VAL;
		end else begin
			reset_cause_register <= next_cause;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// restart vector toward the core, one-cycle request
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			restart <= '{valid: 1'b1, pc: `PC_RESET};
		end else begin
			restart.valid <= any_event;
			if (ev.por || ev.bor || ev.master_clear_input || ev.software_reset_flag || ev.wdt_timeout || ev.trap || ev.illop) begin
				restart.pc <= `PC_RESET;
			end else if (ev.wdt_wake) begin
				restart.pc <= cur_pc + `PC_STEP;
			end else if (ev.irq_wake) begin
				restart.pc <= ev.irq_vec_valid ? irq_vector : cur_pc + `PC_STEP;
			end else if (ev.clk_fail) begin
				restart.pc <= `PC_CLKFAIL;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// interrupt: a flag rising sets status; set beats a clear in the same cycle
	assign cause_set = next_cause & ~reset_cause_register;

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			irq_status <= {`CAUSE_W{1'b0}};
			irq_enable <= {`CAUSE_W{1'b0}};
			irq        <= 1'b0;
		end else begin
			if (sw_en_wr) begin
				irq_enable <= w_data[`CAUSE_W-1:0];
			end
			irq_status <= (irq_status & ~(sw_clr_wr ? w_data[`CAUSE_W-1:0] : {`CAUSE_W{1'b0}})) | cause_set;
			irq        <= |(irq_status & irq_enable);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// quarter phase divider: four clk periods per instruction cycle
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			quarter            <= 2'h0;
			cycle_clock_output <= 1'b0;
		end else begin
			quarter            <= quarter + 2'h1;
			cycle_clock_output <= ((quarter + 2'h1) >= `Q_HIGH_FIRST);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// checks
	AST_POR_FLAGS: assert property (@(posedge clk) disable iff (!rst_n)
		ev.por |=> (reset_cause_register == `CAUSE_POR_VAL) && restart.pc == `PC_RESET)
		else $error("power-on flags or pc wrong");
	AST_BOR_FLAGS: assert property (@(posedge clk) disable iff (!rst_n)
		ev.bor && !ev.por |=> reset_cause_register[`B_BOR] && !reset_cause_register[`B_POR])
		else $error("brown-out flags wrong");
	AST_SWR_FLAGS: assert property (@(posedge clk) disable iff (!rst_n)
		ev.software_reset_flag && !(ev.por || ev.bor || ev.master_clear_input) |=> reset_cause_register[`B_SWR] &&
		!reset_cause_register[`B_EXT] && !reset_cause_register[`B_SLEEP])
		else $error("software reset flags wrong");
	AST_MASTER_CLEAR_INPUT_FLAGS: assert property (@(posedge clk) disable iff (!rst_n)
		ev.master_clear_input && !(ev.por || ev.bor) |=> reset_cause_register[`B_EXT] &&
		!reset_cause_register[`B_WDT] && reset_cause_register[`B_IDLE] == $past(ctrl[`C_IDLING]))
		else $error("master clear flags wrong");
	AST_MASTER_CLEAR_INPUT_IDLE: assert property (@(posedge clk) disable iff (!rst_n)
		ev.master_clear_input && ctrl[`C_IDLING] && !(ev.por || ev.bor) |=>
		reset_cause_register[`B_SWR] == $past(reset_cause_register[`B_SWR]) && !reset_cause_register[`B_SLEEP])
		else $error("idle master clear kept wrong flags");
	AST_WDT_RESET: assert property (@(posedge clk) disable iff (!rst_n)
		ev.wdt_timeout && !(ev.por || ev.bor || ev.master_clear_input || ev.software_reset_flag) |=>
		reset_cause_register[`B_WDT] && !reset_cause_register[`B_SWR] && restart.pc == `PC_RESET)
		else $error("watchdog reset wrong");
	AST_WDT_WAKE: assert property (@(posedge clk) disable iff (!rst_n)
		ev.wdt_wake && !(ev.por || ev.bor || ev.master_clear_input || ev.software_reset_flag || ev.wdt_timeout || ev.trap || ev.illop) |=>
		restart.pc == $past(cur_pc) + `PC_STEP && reset_cause_register[`B_SLEEP])
		else $error("watchdog wake wrong");
	AST_IRQ_VEC: assert property (@(posedge clk) disable iff (!rst_n)
		ev.irq_wake && ev.irq_vec_valid && !(ev.por || ev.bor || ev.master_clear_input || ev.software_reset_flag ||
		ev.wdt_timeout || ev.trap || ev.illop || ev.wdt_wake) |=> restart.pc == $past(irq_vector))
		else $error("interrupt vector not loaded");
	AST_CLKFAIL: assert property (@(posedge clk) disable iff (!rst_n)
		ev.clk_fail && !(any_event && !ev.clk_fail) && !(ev.por || ev.bor || ev.master_clear_input || ev.software_reset_flag ||
		ev.wdt_timeout || ev.trap || ev.illop || ev.wdt_wake || ev.irq_wake) && !sw_cause_wr |=>
		restart.pc == `PC_CLKFAIL && $stable(reset_cause_register))
		else $error("clock failure changed flags");
	AST_CYCLE_CLK: assert property (@(posedge clk) disable iff (!rst_n)
		$rose(cycle_clock_output) |-> cycle_clock_output [*2] ##1 !cycle_clock_output [*2] ##1 cycle_clock_output)
		else $error("cycle clock not two low two high");

	// quarter counter steps by one on every clock after reset
	AST_QUARTER_STEP: assert property (@(posedge clk) disable iff (!rst_n)
		$past(rst_n) |-> quarter == 2'($past(quarter) + 2'h1))
		else $error("quarter phase skipped");

	// clock output low in quarters zero and one, high in two and three
	AST_CLK_PHASE: assert property (@(posedge clk) disable iff (!rst_n)
		cycle_clock_output == quarter[1])
		else $error("cycle clock out of phase");

	// full software write lands when no event competes in that cycle
	AST_SW_WRITE: assert property (@(posedge clk) disable iff (!rst_n)
		sw_cause_wr && w_strb[0] && w_strb[1] && !(ev.por || ev.bor || ev.master_clear_input || ev.software_reset_flag ||
		ev.wdt_timeout || ev.trap || ev.illop || ev.wdt_wake || ev.irq_wake) |=>
		reset_cause_register == $past(w_data[`CAUSE_W-1:0]))
		else $error("software write to cause flags lost");

	// trap reset sets its own flag and restarts at zero
	AST_TRAP_FLAG: assert property (@(posedge clk) disable iff (!rst_n)
		ev.trap && !(ev.por || ev.bor || ev.master_clear_input || ev.software_reset_flag || ev.wdt_timeout) |=>
		reset_cause_register[`B_TRAP] && restart.pc == `PC_RESET)
		else $error("trap reset wrong");

	// illegal operation reset sets its own flag and restarts at zero
	AST_ILLOP_FLAG: assert property (@(posedge clk) disable iff (!rst_n)
		ev.illop && !(ev.por || ev.bor || ev.master_clear_input || ev.software_reset_flag || ev.wdt_timeout || ev.trap) |=>
		reset_cause_register[`B_ILLOP] && restart.pc == `PC_RESET)
		else $error("illegal operation reset wrong");

	// interrupt wake sets only the sleep flag, the rest kept
	AST_IRQ_WAKE_FLAGS: assert property (@(posedge clk) disable iff (!rst_n)
		ev.irq_wake && !(ev.por || ev.bor || ev.master_clear_input || ev.software_reset_flag || ev.wdt_timeout || ev.trap ||
		ev.illop || ev.wdt_wake) |=> reset_cause_register[`B_SLEEP] &&
		reset_cause_register[`B_SLEEP-1:0] == $past(reset_cause_register[`B_SLEEP-1:0]) &&
		reset_cause_register[`B_BOR:`B_POR] == $past(reset_cause_register[`B_BOR:`B_POR]))
		else $error("interrupt wake changed other flags");

	// restart request is a single pulse one clock after each event
	AST_RESTART_PULSE: assert property (@(posedge clk) disable iff (!rst_n)
		$past(rst_n) |-> restart.valid == $past(any_event))
		else $error("restart request pulse wrong");

	// interrupt level follows enabled status one clock later
	AST_IRQ_LEVEL: assert property (@(posedge clk) disable iff (!rst_n)
		$past(rst_n) |-> irq == |($past(irq_status) & $past(irq_enable)))
		else $error("interrupt level wrong");

	COV_POR:  cover property (@(posedge clk) disable iff (!rst_n) ev.por ##1 restart.valid);
	COV_CLKF: cover property (@(posedge clk) disable iff (!rst_n) ev.clk_fail);
	COV_IDLE: cover property (@(posedge clk) disable iff (!rst_n) ev.master_clear_input && ctrl[`C_IDLING]);
	COV_WAKE: cover property (@(posedge clk) disable iff (!rst_n) ev.irq_wake && ev.irq_vec_valid);
	COV_IRQ:  cover property (@(posedge clk) disable iff (!rst_n) $rose(irq));
endmodule
`default_nettype wire

// >>> core_restart_model.sv
/*
 * Model of the core restart side: pulses reset and wake events into the
 * recorder and captures the restart address the core would jump to.
 * Assumes clk is shared with the recorder and events are one clk wide.
 */
`timescale 1ns/1ps
`default_nettype none
module core_restart_model #(
	parameter logic [23:0] SLEEP_PC = 24'h001230, // pc of the sleep instruction
	parameter logic [23:0] WAKE_VEC = 24'h000040  // vector of the waking interrupt
) (
	input  wire logic                      clk,        // oscillator clock
	input  wire reset_cause_pkg::restart_t restart,    // restart request
	output var  reset_cause_pkg::event_t   ev,         // event pulses
	output wire logic [23:0]               cur_pc,     // pc at sleep
	output wire logic [23:0]               irq_vector  // waking vector
);
	import reset_cause_pkg::*;

	////////////////////////////////////////////////////////////////
	// the core stays parked on one instruction, so pc+2 is fixed
	assign cur_pc = SLEEP_PC;
	assign irq_vector = WAKE_VEC;

	initial begin
		ev = '0;
	end

	////////////////////////////////////////////////////////////////
	// one-cycle event, then wait for the restart request
	task automatic pulse(input event_t e, output logic [23:0] pc);
		int n;
		n = 0;
		ev <= e;
		@(posedge clk);
		ev <= '0;
		do begin
			@(posedge clk);
			n++;
		end while (restart.valid !== 1'b1 && n < 8); // bounded, bench counts a miss
		// a missing restart request yields an address no test expects
		pc = (restart.valid === 1'b1) ? restart.pc : 24'hFFFFFF;
	endtask
endmodule
`default_nettype wire

// >>> reset_cause_flag_recorder_bench.sv
/*
 * Bench for the reset cause recorder: AXI4-Lite tasks, an event table,
 * error responses, interrupt and cycle clock checks.
 * Assumes the package, config header and core model are compiled first.
 */
`timescale 1ns/1ps
`default_nettype none
`include "reset_cause_cfg.svh"
module reset_cause_flag_recorder_bench;
	import reset_cause_pkg::*;
	localparam logic [23:0] SLEEP_PC = 24'h001230;
	localparam logic [23:0] WAKE_VEC = 24'h000040;
	localparam logic [23:0] NEXT_PC  = 24'h001232;
	typedef struct packed {
		event_t      e;
		logic [8:0]  pre;
		logic [1:0]  mode;
		logic [8:0]  post;
		logic [23:0] pc;
	} row_t;
	// event, flags before, ctrl mode, flags after, restart address
	localparam row_t ROWS [13] = '{
		'{11'h200, 9'h0FF, 2'h0, 9'h17F, 24'h0},
		'{11'h080, 9'h1F7, 2'h0, 9'h18B, 24'h0},
		'{11'h100, 9'h1FB, 2'h0, 9'h187, 24'h0},
		'{11'h100, 9'h1BB, 2'h1, 9'h1CF, 24'h0},
		'{11'h100, 9'h1DB, 2'h2, 9'h1AF, 24'h0},
		'{11'h040, 9'h1EF, 2'h0, 9'h193, 24'h0},
		'{11'h002, 9'h1FC, 2'h0, 9'h1FD, 24'h0},
		'{11'h001, 9'h1FD, 2'h0, 9'h1FF, 24'h0},
		'{11'h020, 9'h0A5, 2'h1, 9'h0F5, NEXT_PC},
		'{11'h010, 9'h125, 2'h1, 9'h165, NEXT_PC},
		'{11'h018, 9'h000, 2'h1, 9'h040, WAKE_VEC},
		'{11'h004, 9'h1A5, 2'h0, 9'h1A5, 24'h000004},
		'{11'h400, 9'h07F, 2'h0, 9'h180, 24'h0}
	};

	logic        clk = 1'b0;
	logic        rst_n = 1'b0;
	event_t      ev;
	logic [23:0] cur_pc;
	logic [23:0] irq_vector;
	logic [31:0] s_awaddr, s_wdata, s_araddr, s_rdata;
	logic [3:0]  s_wstrb;
	logic        s_awvalid, s_awready, s_wvalid, s_wready, s_bvalid, s_bready;
	logic        s_arvalid, s_arready, s_rvalid, s_rready;
	logic [1:0]  s_bresp, s_rresp, quarter;
	restart_t    restart;
	logic        cycle_clock_output, irq;
	int          fail_count = 0;
	int          check_count = 0;

	always #25 clk = ~clk;

	reset_cause_flag_recorder i_reset_cause_flag_recorder (
		.clk(clk), .rst_n(rst_n), .ev(ev), .cur_pc(cur_pc), .irq_vector(irq_vector),
		.s_awaddr(s_awaddr), .s_awvalid(s_awvalid), .s_awready(s_awready),
		.s_wdata(s_wdata), .s_wstrb(s_wstrb), .s_wvalid(s_wvalid), .s_wready(s_wready),
		.s_bresp(s_bresp), .s_bvalid(s_bvalid), .s_bready(s_bready),
		.s_araddr(s_araddr), .s_arvalid(s_arvalid), .s_arready(s_arready),
		.s_rdata(s_rdata), .s_rresp(s_rresp), .s_rvalid(s_rvalid), .s_rready(s_rready),
		.restart(restart), .cycle_clock_output(cycle_clock_output),
		.quarter(quarter), .irq(irq));

	core_restart_model #(.SLEEP_PC(SLEEP_PC), .WAKE_VEC(WAKE_VEC)) i_core_restart_model (
		.clk(clk), .restart(restart), .ev(ev), .cur_pc(cur_pc), .irq_vector(irq_vector));

	////////////////////////////////////////////////////////////////
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			fail_count++;
			$display("ERROR at %0t: saw %h, expected %h", $time, seen, exp);
		end
	endtask

	task automatic report_and_stop;
		$display("checks %0d, mismatches %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	// write: address and data offered together, each dropped once taken
	task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		logic aw;
		logic w;
		aw = 1'b0;
		w = 1'b0;
		s_awaddr <= {24'h0, a};
		s_wdata <= d;
		s_awvalid <= 1'b1;
		s_wvalid <= 1'b1;
		while (!(aw && w)) begin
			@(posedge clk);
			if (!aw && s_awready === 1'b1) begin
				aw = 1'b1;
				s_awvalid <= 1'b0;
			end
			if (!w && s_wready === 1'b1) begin
				w = 1'b1;
				s_wvalid <= 1'b0;
			end
		end
		do @(posedge clk); while (s_bvalid !== 1'b1);
		r = s_bresp;
	endtask

	task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		s_araddr <= {24'h0, a};
		s_arvalid <= 1'b1;
		do @(posedge clk); while (s_arready !== 1'b1);
		s_arvalid <= 1'b0;
		do @(posedge clk); while (s_rvalid !== 1'b1);
		d = s_rdata;
		r = s_rresp;
	endtask

	////////////////////////////////////////////////////////////////
	// response channels stay ready: legal and keeps the drivers simple
	initial begin
		int          i;
		logic [31:0] d;
		logic [1:0]  r;
		logic [23:0] pc;
		logic [1:0]  q [8];
		logic        c [8];
		{s_awaddr, s_wdata, s_araddr, s_awvalid, s_wvalid, s_arvalid} = '0;
		s_wstrb = 4'hF;
		s_bready = 1'b1;
		s_rready = 1'b1;
		repeat (5) @(posedge clk);
		chk(32'(restart.pc), 32'h0);
		rst_n <= 1'b1;
		@(posedge clk);
		rd(`OFS_CAUSE, d, r);
		chk(d, 32'h180);
		foreach (ROWS[k]) begin
			wr(`OFS_CAUSE, 32'(ROWS[k].pre), r);
			chk(32'(r), 32'(`AXI_OKAY));
			wr(`OFS_CTRL, 32'(ROWS[k].mode), r);
			rd(`OFS_CAUSE, d, r);
			chk(32'(r), 32'(`AXI_OKAY));
			chk(d, 32'(ROWS[k].pre));
			i_core_restart_model.pulse(ROWS[k].e, pc);
			chk(32'(pc), 32'(ROWS[k].pc));
			rd(`OFS_CAUSE, d, r);
			chk(d, 32'(ROWS[k].post));
			rd(`OFS_RESTART, d, r);
			chk(d, 32'(ROWS[k].pc));
		end
		// refused accesses: read-only write and an unmapped read
		wr(`OFS_IRQ_STATUS, 32'h1, r);
		chk(32'(r), 32'(`AXI_SLVERR));
		rd(8'h40, d, r);
		chk(32'(r), 32'(`AXI_SLVERR));
		chk(d, 32'h0);
		// interrupt raised masked, then enabled, then cleared
		wr(`OFS_IRQ_ENABLE, 32'h0, r);
		wr(`OFS_CAUSE, 32'h0, r);
		wr(`OFS_IRQ_CLEAR, 32'h1FF, r);
		i_core_restart_model.pulse(event_t'(11'h002), pc);
		rd(`OFS_IRQ_STATUS, d, r);
		chk(d, 32'h1);
		chk(32'(irq), 32'h0);
		wr(`OFS_IRQ_ENABLE, 32'h1, r);
		repeat (2) @(posedge clk);
		chk(32'(irq), 32'h1);
		wr(`OFS_IRQ_CLEAR, 32'h1, r);
		repeat (2) @(posedge clk);
		chk(32'(irq), 32'h0);
		rd(`OFS_IRQ_CLEAR, d, r);
		chk(d, 32'h0);
		// two full instruction cycles of phase and clock output
		for (i = 0; i < 8; i++) begin
			@(posedge clk);
			q[i] = quarter;
			c[i] = cycle_clock_output;
		end
		for (i = 1; i < 8; i++) begin
			chk(32'(q[i]), 32'(2'(q[i-1] + 2'h1)));
			chk(32'(c[i]), 32'(q[i][1]));
		end
		report_and_stop;
	end

	// watchdog: the tests need well under a tenth of this span
	initial begin
		repeat (20000) @(posedge clk);
		fail_count++;
		report_and_stop;
	end
endmodule
`default_nettype wire
